// File: common/nchar_pkg.sv
// constants shared by the packet-character word packer and its lane mapper
// assumes a single core clock domain and no software-visible registers
package nchar_pkg;
    localparam int unsigned        LANES        = 4;
    localparam int unsigned        SYM_W        = 8;
    localparam int unsigned        CHAR_W       = 9;
    localparam int unsigned        CTRL_BIT     = 8;
    localparam int unsigned        POS_W        = 3;
    localparam int unsigned        FCNT_W       = 7;
    localparam int unsigned        MAX_FRAME_WORDS = 64;
    // 8b/10b special symbols before the line coder (x in 4:0, y in 7:5)
    localparam logic [7:0]         SYM_EOP      = 8'hfd;
    localparam logic [7:0]         SYM_EEP      = 8'hfe;
    localparam logic [7:0]         SYM_FILL     = 8'hfb;
    // internal control codes, control flag set
    localparam logic [7:0]         CODE_EOP     = 8'h00;
    localparam logic [7:0]         CODE_EEP     = 8'h01;
    localparam logic [7:0]         CODE_FILL    = 8'h02;
    localparam logic [8:0]         CHAR_FILL    = {1'b1, CODE_FILL};
    localparam logic [2:0]         POS_FULL     = 3'h4;
endpackage

// File: hw/nchar_symbol_map.sv
// one lane of character to symbol mapping, both directions, combinational
// assumes symbols carry a separate k flag beside the byte
`timescale 1ns/10ps
`default_nettype none
module nchar_symbol_map
(
    input  wire logic [8:0] i_tx_char,
    output logic      [7:0] o_tx_sym,
    output logic            o_tx_k,
    input  wire logic [7:0] i_rx_sym,
    input  wire logic       i_rx_k,
    output logic      [8:0] o_rx_char,
    output logic            o_rx_eop,
    output logic            o_rx_eep,
    output logic            o_rx_fill,
    output logic            o_rx_bad
);
    // ----------------------------------------
    // transmit direction
    // ----------------------------------------
    always_comb
    begin
        o_tx_k   = i_tx_char[nchar_pkg::CTRL_BIT];
        o_tx_sym = i_tx_char[7:0];
        if (o_tx_k)
        begin
            case (i_tx_char[7:0])
                nchar_pkg::CODE_EOP: o_tx_sym = nchar_pkg::SYM_EOP;
                nchar_pkg::CODE_EEP: o_tx_sym = nchar_pkg::SYM_EEP;
                // fill symbol; unknown codes also go out as fill, safest choice
                default:             o_tx_sym = nchar_pkg::SYM_FILL;
            endcase
        end
    end

    // ----------------------------------------
    // receive direction
    // ----------------------------------------
    always_comb
    begin
        o_rx_char = {1'b0, i_rx_sym};
        o_rx_eop  = 1'b0;
        o_rx_eep  = 1'b0;
        o_rx_fill = 1'b0;
        o_rx_bad  = 1'b0;
        if (i_rx_k)
        begin
            case (i_rx_sym)
                nchar_pkg::SYM_EOP:
                begin
                    o_rx_char = {1'b1, nchar_pkg::CODE_EOP};
                    o_rx_eop  = 1'b1;
                end
                nchar_pkg::SYM_EEP:
                begin
                    o_rx_char = {1'b1, nchar_pkg::CODE_EEP};
                    o_rx_eep  = 1'b1;
                end
                // fill is ordinary traffic, never an error
                nchar_pkg::SYM_FILL:
                begin
                    o_rx_char = nchar_pkg::CHAR_FILL;
                    o_rx_fill = 1'b1;
                end
                default:
                begin
                    o_rx_char = nchar_pkg::CHAR_FILL;
                    o_rx_bad  = 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/nchar_word_packer.sv
// packs buffer characters into four-symbol words and unpacks received words
// assumes the frame layer adds control words; input buffer accepts every word
`timescale 1ns/10ps
`default_nettype none
module nchar_word_packer
#(
    parameter int unsigned FRAME_WORDS = nchar_pkg::MAX_FRAME_WORDS
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_tx_char_valid,
    input  wire logic [8:0]  i_tx_char,
    output logic             o_tx_char_ready,
    output logic             o_tx_word_valid,
    output logic      [31:0] o_tx_word,
    output logic      [3:0]  o_tx_k,
    output logic             o_tx_frame_last,
    input  wire logic        i_tx_word_ready,
    input  wire logic        i_rx_word_valid,
    input  wire logic [31:0] i_rx_word,
    input  wire logic [3:0]  i_rx_k,
    output logic             o_rx_valid,
    output logic      [35:0] o_rx_chars,
    output logic      [3:0]  o_rx_eop,
    output logic      [3:0]  o_rx_eep,
    output logic      [3:0]  o_rx_sop,
    output logic      [3:0]  o_rx_fill,
    output logic             o_rx_bad
);
    // the frame counter and its last-word mark serve only 1..64 words
    if (FRAME_WORDS < 1 || FRAME_WORDS > nchar_pkg::MAX_FRAME_WORDS)
    begin : g_bad_frame_words
        $error("FRAME_WORDS must lie in 1..64");
    end

    localparam logic [6:0] LAST_CNT = 7'(FRAME_WORDS - 1);

    typedef struct packed {
        logic [3:0][8:0]  lane;
        logic [2:0]       pos;
        logic             last_end;
        logic             ready;
        logic [31:0]      tx_word;
        logic [3:0]       tx_k;
        logic             tx_valid;
        logic             tx_last;
        logic [6:0]       fcnt;
        logic [35:0]      rx_chars;
        logic [3:0]       rx_eop;
        logic [3:0]       rx_eep;
        logic [3:0]       rx_sop;
        logic [3:0]       rx_fill;
        logic             rx_bad;
        logic             rx_valid;
        logic             expect_first;
    } state_t;

    state_t           s_q;
    state_t           s_d;
    logic [3:0][8:0]  pad_char;
    logic [3:0][7:0]  tx_sym;
    logic [3:0]       tx_kf;
    logic [3:0][8:0]  rx_char;
    logic [3:0]       rx_eop_l;
    logic [3:0]       rx_eep_l;
    logic [3:0]       rx_fill_l;
    logic [3:0]       rx_bad_l;
    logic             take;
    logic             can_emit;
    logic             flush;

    // ----------------------------------------
    // lane mappers
    // ----------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        // lanes past the fill point carry fill
        assign pad_char[g] = (3'(g) < s_q.pos) ? s_q.lane[g] : nchar_pkg::CHAR_FILL;
        nchar_symbol_map u_map
        (
            .i_tx_char (pad_char[g]),
            .o_tx_sym  (tx_sym[g]),
            .o_tx_k    (tx_kf[g]),
            .i_rx_sym  (i_rx_word[8*g +: 8]),
            .i_rx_k    (i_rx_k[g]),
            .o_rx_char (rx_char[g]),
            .o_rx_eop  (rx_eop_l[g]),
            .o_rx_eep  (rx_eep_l[g]),
            .o_rx_fill (rx_fill_l[g]),
            .o_rx_bad  (rx_bad_l[g])
        );
    end

    assign take     = s_q.ready && i_tx_char_valid;
    assign can_emit = !s_q.tx_valid || i_tx_word_ready;
    // flush a tail after an end marker once the source goes quiet
    assign flush    = can_emit && ((s_q.pos == nchar_pkg::POS_FULL)
                      || (s_q.pos != 3'h0 && s_q.last_end && !take));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic exp_first;
        exp_first = s_q.expect_first;
        s_d       = s_q;
        if (s_q.tx_valid && i_tx_word_ready)
            s_d.tx_valid = 1'b0;
        // any lane accepts any character, end markers included
        if (take)
        begin
            s_d.lane[s_q.pos[1:0]] = i_tx_char;
            s_d.pos                = s_q.pos + 3'h1;
            // only an end marker lets a short word go; unknown codes count as fill
            s_d.last_end           = i_tx_char[nchar_pkg::CTRL_BIT]
                                     && (i_tx_char[7:0] == nchar_pkg::CODE_EOP
                                     || i_tx_char[7:0] == nchar_pkg::CODE_EEP);
        end
        // always four symbols; padding only behind a nonempty word
        if (flush)
        begin
            s_d.tx_word  = tx_sym;
            s_d.tx_k     = tx_kf;
            s_d.tx_valid = 1'b1;
            s_d.pos      = 3'h0;
            s_d.last_end = 1'b0;
            // mark the last word of each frame
            s_d.tx_last  = (s_q.fcnt == LAST_CNT);
            s_d.fcnt     = (s_q.fcnt == LAST_CNT) ? 7'h00 : s_q.fcnt + 7'h01;
        end
        // ready is registered from the next position, so it drops in the same cycle the word becomes full
        s_d.ready = (s_d.pos != nchar_pkg::POS_FULL);

        s_d.rx_valid = i_rx_word_valid;
        if (i_rx_word_valid)
        begin
            // first received character sits in the low lane
            s_d.rx_chars = rx_char;
            // fills are written on with the rest
            s_d.rx_fill  = rx_fill_l;
            // end markers close the packet, eep flags the error
            s_d.rx_eop   = rx_eop_l;
            s_d.rx_eep   = rx_eep_l;
            s_d.rx_bad   = |rx_bad_l;
            for (int i = 0; i < 4; i++)
            begin
                // first data after an end marker opens the next packet
                s_d.rx_sop[i] = exp_first && !rx_char[i][nchar_pkg::CTRL_BIT];
                if (!rx_char[i][nchar_pkg::CTRL_BIT])
                    exp_first = 1'b0;
                if (rx_eop_l[i] || rx_eep_l[i])
                    exp_first = 1'b1;
            end
            s_d.expect_first = exp_first;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_q              <= '0;
            s_q.expect_first <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_tx_char_ready = s_q.ready;
    assign o_tx_word_valid = s_q.tx_valid;
    assign o_tx_word       = s_q.tx_word;
    assign o_tx_k          = s_q.tx_k;
    assign o_tx_frame_last = s_q.tx_last;
    assign o_rx_valid      = s_q.rx_valid;
    assign o_rx_chars      = s_q.rx_chars;
    assign o_rx_eop        = s_q.rx_eop;
    assign o_rx_eep        = s_q.rx_eep;
    assign o_rx_sop        = s_q.rx_sop;
    assign o_rx_fill       = s_q.rx_fill;
    assign o_rx_bad        = s_q.rx_bad;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_full_stalls_input: assert property (s_q.pos == 3'h4 |-> !o_tx_char_ready)
        else $error("ready while word full");
    a_full_word_sent: assert property (s_q.pos == 3'h4 && can_emit |=> o_tx_word_valid
        && s_q.pos == 3'h0)
        else $error("full word not sent");
    a_tail_padded: assert property (s_q.pos != 3'h0 && s_q.pos != 3'h4 && s_q.last_end
        && !take && can_emit |=> o_tx_word_valid && o_tx_k[3]
        && o_tx_word[31:24] == nchar_pkg::SYM_FILL)
        else $error("tail not padded with fill");
    a_no_empty_pad: assert property (!(flush && s_q.pos == 3'h0))
        else $error("word of four fills made by padding");
    a_data_symbol: assert property (flush && !s_q.lane[0][8] && s_q.pos != 3'h0
        |=> !o_tx_k[0] && o_tx_word[7:0] == $past(s_q.lane[0][7:0]))
        else $error("data byte not carried unchanged");
    a_word_held: assert property (o_tx_word_valid && !i_tx_word_ready
        |=> o_tx_word_valid && $stable(o_tx_word))
        else $error("word dropped under back-pressure");
    a_frame_last: assert property (flush && s_q.fcnt == LAST_CNT |=> o_tx_frame_last
        ##0 s_q.fcnt == 7'h00)
        else $error("frame length not marked");
    a_rx_eop_lane: assert property (i_rx_word_valid && i_rx_k[1]
        && i_rx_word[15:8] == nchar_pkg::SYM_EOP |=> o_rx_eop[1] && !o_rx_bad)
        else $error("eop not decoded");
    a_rx_eep_lane: assert property (i_rx_word_valid && i_rx_k[0]
        && i_rx_word[7:0] == nchar_pkg::SYM_EEP |=> o_rx_eep[0] && !o_rx_eop[0])
        else $error("eep not decoded");
    a_rx_sop_follow: assert property (i_rx_word_valid && i_rx_k[0]
        && i_rx_word[7:0] == nchar_pkg::SYM_EOP && !i_rx_k[1] |=> o_rx_sop[1])
        else $error("next packet start missed");
    a_rx_fill_kept: assert property (i_rx_word_valid && i_rx_k[2]
        && i_rx_word[23:16] == nchar_pkg::SYM_FILL |=> o_rx_valid && o_rx_fill[2]
        && !o_rx_bad)
        else $error("fill dropped or flagged");

    c_three_fills: cover property (flush && s_q.pos == 3'h1);
    c_frame_end: cover property (o_tx_frame_last && o_tx_word_valid);
    c_stall: cover property (o_tx_word_valid && !i_tx_word_ready [*2]);
    c_rx_eep: cover property (o_rx_valid && |o_rx_eep);
endmodule
`default_nettype wire

// File: tb/nchar_word_packer_tb.sv
// bench for the word packer: partner feeds characters, words loop back to rx
// assumes FRAME_WORDS of 4 and the control codes of the package
`timescale 1ns/10ps
`default_nettype none
module nchar_word_packer_tb;
    localparam int FW = 4;
    logic i_core_clk, i_rst_n, cv, cr, wv, wl, wr, stall, rv, ov, ob, pend, start;
    logic [8:0] ch, s;
    logic [31:0] tw, rw;
    logic [3:0] tk, rk, oe, oee, os, of, ee, eep, es, ef, unk;
    logic [35:0] oc, ec, e;
    logic eb;
    logic [8:0] lanes[$];
    logic [35:0] exp_tx[$], rx_q[$];
    int error_cnt, checked, seed, wcnt, cycles;
    nchar_word_packer #(.FRAME_WORDS(FW)) u_nchar_word_packer (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_tx_char_valid(cv), .i_tx_char(ch), .o_tx_char_ready(cr),
        .o_tx_word_valid(wv), .o_tx_word(tw), .o_tx_k(tk), .o_tx_frame_last(wl),
        .i_tx_word_ready(wr), .i_rx_word_valid(rv), .i_rx_word(rw), .i_rx_k(rk),
        .o_rx_valid(ov), .o_rx_chars(oc), .o_rx_eop(oe), .o_rx_eep(oee), .o_rx_sop(os),
        .o_rx_fill(of), .o_rx_bad(ob));
    chan_buffer_model u_chan_buffer_model (.i_core_clk(i_core_clk), .i_stall(stall),
        .i_char_ready(cr),
        .o_char_valid(cv), .o_char(ch), .o_word_ready(wr));
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // reference packer: symbol as {k, byte}
    // ----------------------------------------
    task automatic add(input logic [8:0] c, input bit src = 1'b1);
        logic [8:0] m;
        if (src)
            u_chan_buffer_model.push(c);
        m = !c[8] ? c : (c[7:0] == 8'h00) ? 9'h1fd : (c[7:0] == 8'h01) ? 9'h1fe : 9'h1fb;
        lanes.push_back(m);
        if (lanes.size() == 4)
        begin
            for (int i = 0; i < 4; i++)
                {e[32 + i], e[8 * i +: 8]} = lanes[i];
            exp_tx.push_back(e);
            lanes.delete();
        end
    endtask
    task automatic burst(input int n, input logic [8:0] ender);
        int r;
        for (int i = 0; i < n; i++)
        begin
            r = $random(seed);
            case (r[3:0])
                4'ha: add(9'h102);
                4'hb: add(9'h1a5);
                4'hc: add(9'h100);
                4'hd: add(9'h101);
                default: add({1'b0, r[11:4]});
            endcase
        end
        add(ender);
        // the source goes quiet after the end marker: the packer must pad by itself
        while (lanes.size() != 0)
            add(9'h102, 1'b0);
        for (int t = 0; t < 300 && (exp_tx.size() + rx_q.size() != 0 || pend); t++)
            @(negedge i_core_clk);
    endtask
    // ----------------------------------------
    // word stall, tx compare, rx drive and compare
    // ----------------------------------------
    always @(negedge i_core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
        stall = i_rst_n && ($random(seed) % 4 == 0);
        if (wv && !stall && i_rst_n)
        begin
            e = exp_tx.size() > 0 ? exp_tx.pop_front() : 36'hx;
            chk({wl, tk, tw}, {(wcnt % FW) == FW - 1, e});
            wcnt++;
            rx_q.push_back({tk, tw});
        end
        chk(ov, pend);
        if (pend)
        begin
            chk({oc, oe, oee, os, of & ~unk, ob}, {ec, ee, eep, es, ef & ~unk, eb});
        end
        pend = rx_q.size() > 0;
        rv = pend;
        {rk, rw} = pend ? rx_q.pop_front() : {~rk, ~rw};
        eb = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            s = {rk[i], rw[8 * i +: 8]};
            ee[i] = s == 9'h1fd;
            eep[i] = s == 9'h1fe;
            ef[i] = s == 9'h1fb;
            unk[i] = s[8] && !ee[i] && !eep[i] && !ef[i];
            eb = eb | unk[i];
            ec[9 * i +: 9] = !s[8] ? s : ee[i] ? 9'h100 : eep[i] ? 9'h101 : 9'h102;
            es[i] = !s[8] && start;
            if (pend && !s[8])
                start = 1'b0;
            if (pend && (ee[i] || eep[i]))
                start = 1'b1;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 45761;
        {error_cnt, checked, wcnt, cycles} = '0;
        {i_rst_n, stall, rv, pend} = '0;
        {rw, rk} = '0;
        start = 1'b1;
        repeat (6) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        @(negedge i_core_clk);
        chk({cr, wv, ov}, 3'b100);
        // byte boundaries then a one-character tail
        add(9'h000);
        add(9'h0ff);
        add(9'h039);
        add(9'h080);
        burst(0, 9'h100);
        for (int b = 0; b < 40; b++)
            burst($random(seed) & 11, b[0] ? 9'h101 : 9'h100);
        // unknown k in lane 0, then fill, end, error end, fill
        rx_q.push_back({4'b0001, 32'h39fb_00bc});
        rx_q.push_back({4'b1111, 32'hfbfe_fdfb});
        rx_q.push_back({4'b0000, 32'h0102_0304});
        repeat (8) @(negedge i_core_clk);
        chk(exp_tx.size() + rx_q.size() + lanes.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire

// File: tb/vcb_model.sv
// buffer-side partner: offers queued characters, accepts words on demand
// assumes the bench pushes characters and drives the word stall pattern
`timescale 1ns/10ps
`default_nettype none
module chan_buffer_model
(
    input  wire logic       i_core_clk,
    input  wire logic       i_stall,
    input  wire logic       i_char_ready,
    output logic            o_char_valid,
    output logic      [8:0] o_char,
    output logic            o_word_ready
);
    logic [8:0] q_chars[$];
    logic       taken;
    assign o_word_ready = !i_stall;
    task automatic push(input logic [8:0] c);
        q_chars.push_back(c);
    endtask
    initial
    begin
        o_char_valid = 1'b0;
        o_char       = 9'h155;
        taken        = 1'b0;
    end
    always @(posedge i_core_clk)
        taken <= o_char_valid && i_char_ready;
    // ----------------------------------------
    // nine-bit characters, arrival order
    // ----------------------------------------
    always @(negedge i_core_clk)
    begin
        if (taken && q_chars.size() > 0)
            void'(q_chars.pop_front());
        o_char_valid = q_chars.size() > 0;
        // idle line moves every cycle so a stale character never looks valid
        o_char       = o_char_valid ? q_chars[0] : ~o_char;
    end
endmodule
`default_nettype wire
